// ---- rtl/charger_pkg.sv ----
package charger_pkg;

  // register word addresses (printed offsets not all multiples of 4)
  localparam logic [7:0] IDX_FAULT   = 8'h00;
  localparam logic [7:0] IDX_LIMIT   = 8'h01;
  localparam logic [7:0] IDX_FLOAT   = 8'h02;
  localparam logic [7:0] IDX_CURRENT = 8'h04;
  localparam logic [7:0] IDX_FLOOR   = 8'h05;
  localparam logic [7:0] IDX_CEILING = 8'h06;
  localparam logic [7:0] IDX_STATUS  = 8'h07;

  // reset values
  localparam logic [7:0] LIMIT_RST   = 8'h00;
  localparam logic [7:0] FLOAT_RST   = 8'h00;
  localparam logic [7:0] CURRENT_RST = 8'h00;
  localparam logic [2:0] FLOOR_RST   = 3'h0;
  localparam logic [7:0] CEILING_RST = 8'h00;

  // field constants
  localparam logic [5:0] VFLOAT_BASE   = 6'h23;
  localparam logic [3:0] VCEIL_TOP     = 4'hC;
  localparam logic [3:0] ICEIL_TOP     = 4'hA;
  localparam logic [3:0] FOLDBACK_CODE = 4'h0;

  // fault codes
  localparam logic [2:0] FAULT_NONE = 3'h0;
  localparam logic [2:0] FAULT_OVP  = 3'h1;
  localparam logic [2:0] FAULT_UV   = 3'h3;
  localparam logic [2:0] FAULT_TSD  = 3'h5;
  localparam logic [1:0] STATUS_FAULT = 2'h3;

  // timing
  localparam int CLK_HZ        = 10_000_000;
  localparam int RETRY_MS      = 2000;
  localparam int RETRY_CYCLES  = CLK_HZ / 1000 * RETRY_MS;
  localparam int PULSE_US      = 128;
  localparam int PULSE_CYCLES  = CLK_HZ / 1_000_000 * PULSE_US;

  // analog comparator flags
  typedef struct packed {
    logic foldback;     // die at or above foldback level
    logic shutdown;     // die above shutdown level
    logic undervolt;    // input below undervoltage level
    logic overvolt;     // input above overvoltage level
    logic ovp_clear;    // input 100 mV below overvoltage level
    logic sleep;        // input below battery plus sleep margin
    logic short_batt;   // battery below short-battery threshold
    logic vin_limit;    // input voltage loop is limiting
  } analog_flags_t;

  // charger state
  typedef enum logic [3:0] {
    ST_CHARGE  = 4'b0001,
    ST_SUSPEND = 4'b0010,
    ST_RETRY   = 4'b0100,
    ST_OVP     = 4'b1000
  } chg_state_t;

  // ceiling lock state
  typedef enum logic [2:0] {
    LK_SHORT = 3'b001,
    LK_OPEN  = 3'b010,
    LK_LOCK  = 3'b100
  } lock_state_t;

endpackage

// ---- rtl/charger_limit_protect_logic.sv ----
// Design decision made here: the APB slave port.
`timescale 1ns/100ps
// How it works
// - input current cap decoded from control bits
// - flag set while input voltage loop limits
// - floor select steps 80 mV from 4.213
// - ceiling register caps float and current
// - ceiling reloads default above short threshold
// - other write locks ceiling until short battery
// - writes above ceiling store the ceiling
// - current ceiling codes 10-15 saturate
// - voltage ceiling code 0x23 plus field
// - foldback forces current code to 550 mA
// - shutdown suspends, fault 101, status pulse
// - suspend freezes retry timer, pulse runs on, resumes on cooling
// - sleep mode blocks reverse current
// - undervoltage stops charge, fault 011, pulse
// - retry after interval once input recovers
// - overvoltage while charging opens switch, fault 001, pulse
// - overvoltage clears at hysteresis, revalidates
// - fault code readable in register zero
module charger_limit_protect_logic #(
  parameter int RETRY_COUNT = charger_pkg::RETRY_CYCLES,
  parameter int PULSE_COUNT = charger_pkg::PULSE_CYCLES
) (
  // clock and reset
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  // apb slave
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [11:0]                paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  // analog comparators, asynchronous
  input  wire charger_pkg::analog_flags_t flags_async,
  // controls to the analog side
  output logic      [1:0]                 input_current_cap,
  output logic      [2:0]                 input_voltage_floor_sel,
  output logic      [5:0]                 float_voltage_code,
  output logic      [3:0]                 charge_current_code,
  output logic                            charge_enable,
  output logic                            input_switch_on,
  output logic                            sleep_mode,
  output logic                            status_pulse
);
  import charger_pkg::*;

  // refuse counts that the counters cannot serve; a zero count would
  // leave the retry state at once and cut the status pulse to one cycle
  if (RETRY_COUNT < 1 || PULSE_COUNT < 1)
  begin
    $error("counts must be at least one");
  end

  // saturate current ceiling field to the top code; codes ten and
  // above all mean the same top current, so they compare as one
  function automatic logic [3:0] icap(input logic [3:0] f);
    icap = (f >= ICEIL_TOP) ? ICEIL_TOP : f;
  endfunction

  // largest float code allowed by the voltage ceiling field; the
  // top four field codes share one ceiling, so the sum never wraps
  function automatic logic [5:0] vcap(input logic [3:0] f);
    logic [3:0] s;
    s = (f >= VCEIL_TOP) ? VCEIL_TOP : f;
    vcap = VFLOAT_BASE + {2'b00, s};
  endfunction

  // registers
  analog_flags_t flags_meta_reg;   // first stage, read only by second
  analog_flags_t flags_reg;        // synchronised flags
  logic [7:0]    limit_reg;        // cap in bits 7:6
  logic [5:0]    float_reg;        // float code in bits 7:2
  logic [3:0]    current_reg;      // current code in bits 7:4
  logic [2:0]    floor_reg;        // floor select in bits 2:0
  logic [7:0]    ceiling_reg;      // ceiling fields
  logic [7:0]    ceil_first_reg;   // first of the two ceiling writes
  logic          ceil_half_reg;    // one ceiling write seen
  // lock and protection state
  lock_state_t   lock_reg;         // ceiling write window
  chg_state_t    state_reg;        // charge, suspend, retry, overvoltage
  logic [2:0]    fault_reg;        // last fault code, kept until next
  logic [1:0]    status_reg;       // status code
  // counters are 32 bits so any positive int count fits
  logic [31:0]   retry_cnt_reg;    // retry interval elapsed
  logic [31:0]   pulse_cnt_reg;    // status pulse cycles left

  // apb decode
  logic       acc;
  logic       wr;
  logic [7:0] widx;
  logic       map_hit;
  logic [7:0] wbyte;
  logic       fault_event;

  // a transfer is in its access cycle while both strobes are high
  assign acc   = psel && penable;
  assign widx  = paddr[9:2];
  assign wr    = acc && pwrite && paddr[1:0] == 2'b00;
  assign wbyte = pwdata[7:0];
  // only aligned addresses of listed words answer without error
  assign map_hit = paddr[1:0] == 2'b00 &&
                   paddr[11:10] == 2'b00 &&
                   (widx == IDX_FAULT || widx == IDX_LIMIT ||
                    widx == IDX_FLOAT || widx == IDX_CURRENT ||
                    widx == IDX_FLOOR || widx == IDX_CEILING ||
                    widx == IDX_STATUS);

  // two-stage synchroniser for analog comparisons
  // the first stage may go metastable; only the second reads it
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flags_meta_reg <= '0;
      flags_reg      <= '0;
    end
    else
    begin
      flags_meta_reg <= flags_async;
      flags_reg      <= flags_meta_reg;
    end
  end

  // single-cycle answer, error on unmapped address
  // pready answers the access cycle after every setup; read data is
  // captured at setup so it stands through the access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !map_hit;
      prdata  <= 32'h0000_0000;
      // only mapped reads load data; unused bits read as zero
      if (psel && !penable && !pwrite && map_hit)
      begin
        case (widx)
          IDX_FAULT:   prdata[2:0] <= fault_reg;
          IDX_LIMIT:   prdata[7:0] <= limit_reg;
          IDX_FLOAT:   prdata[7:2] <= float_reg;
          IDX_CURRENT: prdata[7:4] <= current_reg;
          IDX_FLOOR:   prdata[3:0] <= {flags_reg.vin_limit,
                                       floor_reg};
          IDX_CEILING: prdata[7:0] <= ceiling_reg;
          IDX_STATUS:  prdata[3:0] <= {state_reg == ST_SUSPEND,
                                       sleep_mode, status_reg};
          default:     prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // note: the write takes effect at the access edge; pready is high there
  logic wr_now;
  assign wr_now = wr && pready && map_hit;

  // ordinary control registers; float and current clamped against the ceiling
  // a write above the ceiling stores the ceiling itself, so software
  // reads back what the analog side is really given
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      limit_reg   <= LIMIT_RST;
      float_reg   <= FLOAT_RST[7:2];
      current_reg <= CURRENT_RST[7:4];
      floor_reg   <= FLOOR_RST;
    end
    else if (wr_now)
    begin
      case (widx)
        IDX_LIMIT: limit_reg <= wbyte;
        IDX_FLOAT: float_reg <= (wbyte[7:2] > vcap(ceiling_reg[3:0])) ?
                                vcap(ceiling_reg[3:0]) :
                                wbyte[7:2];
        IDX_CURRENT: current_reg <=
                       (wbyte[7:4] > icap(ceiling_reg[7:4])) ?
                       icap(ceiling_reg[7:4]) : wbyte[7:4];
        IDX_FLOOR: floor_reg <= wbyte[2:0];
        // fault, status and ceiling words are not held here
        default: ;
      endcase
    end
  end

  // ceiling lock: reload above short threshold, lock on double or other
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lock_reg       <= LK_SHORT;
      ceiling_reg    <= CEILING_RST;
      ceil_first_reg <= 8'h00;
      ceil_half_reg  <= 1'b0;
    end
    // short battery wins over everything, so no write can lock the
    // ceiling while the cell is still below the threshold
    else if (flags_reg.short_batt)
    begin
      lock_reg      <= LK_SHORT;
      ceil_half_reg <= 1'b0;
    end
    else
    begin
      case (lock_reg)
        // just rose above the threshold: reload the default
        LK_SHORT:
        begin
          ceiling_reg <= CEILING_RST;
          lock_reg    <= LK_OPEN;
        end
        LK_OPEN:
        begin
          if (wr_now && widx == IDX_CEILING)
          begin
            if (ceil_half_reg && wbyte == ceil_first_reg)
            begin
              ceiling_reg <= wbyte;
              lock_reg    <= LK_LOCK;
            end
            else
            begin
              // an unmatched write becomes the new first write
              ceil_first_reg <= wbyte;
              ceil_half_reg  <= 1'b1;
            end
          end
          // any other register write shuts the window
          else if (wr_now)
            lock_reg <= LK_LOCK;
        end
        LK_LOCK: ;  // writes ignored until short battery
        default: lock_reg <= LK_LOCK;
      endcase
    end
  end

  // protection state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg     <= ST_CHARGE;
      fault_reg     <= FAULT_NONE;
      status_reg    <= 2'b00;
      retry_cnt_reg <= 32'h0000_0000;
    end
    else
    begin
      case (state_reg)
        // overvoltage outranks shutdown, which outranks undervoltage,
        // so from the charge state the input switch opens whatever else is going on
        ST_CHARGE:
        begin
          if (flags_reg.overvolt)
          begin
            state_reg  <= ST_OVP;
            fault_reg  <= FAULT_OVP;
            status_reg <= STATUS_FAULT;
          end
          else if (flags_reg.shutdown)
          begin
            state_reg <= ST_SUSPEND;
            fault_reg <= FAULT_TSD;
          end
          else if (flags_reg.undervolt)
          begin
            state_reg     <= ST_RETRY;
            fault_reg     <= FAULT_UV;
            status_reg    <= STATUS_FAULT;
            retry_cnt_reg <= 32'h0000_0000;
          end
        end
        // the retry count holds while suspended, the status pulse runs on; leave only once cooled
        // below the foldback level as well
        ST_SUSPEND:
          if (!flags_reg.shutdown && !flags_reg.foldback)
            state_reg <= ST_CHARGE;
        // count out the retry interval, then wait for the input
        ST_RETRY:
        begin
          if (retry_cnt_reg < RETRY_COUNT[31:0])
            retry_cnt_reg <= retry_cnt_reg + 32'h0000_0001;
          else if (!flags_reg.undervolt)
          begin
            state_reg  <= ST_CHARGE;
            status_reg <= 2'b00;
          end
        end
        // hysteresis passed: revalidate through retry with the
        // interval already spent, so only the input level decides
        ST_OVP:
          if (flags_reg.ovp_clear && !flags_reg.overvolt)
          begin
            state_reg     <= ST_RETRY;
            status_reg    <= STATUS_FAULT;
            retry_cnt_reg <= RETRY_COUNT[31:0];
          end
        // an illegal code falls back to charging
        default: state_reg <= ST_CHARGE;
      endcase
    end
  end

  // a fault is only reported when leaving the charge state; a second
  // event while already out of charge stays silent
  assign fault_event = state_reg == ST_CHARGE &&
                       (flags_reg.overvolt || flags_reg.shutdown ||
                        flags_reg.undervolt);

  // status pulse stretcher: the pin stays high PULSE_COUNT cycles
  // from the event; a fault only ever fires from the charge state, so
  // a running pulse restarts only if charging resumed before it ran out
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pulse_cnt_reg <= 32'h0000_0000;
      status_pulse  <= 1'b0;
    end
    else if (fault_event)
    begin
      pulse_cnt_reg <= PULSE_COUNT[31:0];
      status_pulse  <= 1'b1;
    end
    // count down to one, then drop the pin
    else if (pulse_cnt_reg > 32'h0000_0001)
      pulse_cnt_reg <= pulse_cnt_reg - 32'h0000_0001;
    else
    begin
      pulse_cnt_reg <= 32'h0000_0000;
      status_pulse  <= 1'b0;
    end
  end

  // registered outputs to the analog side
  // every output leaves a flip-flop, so the analog side never sees
  // decode glitches from the bus or the state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      input_current_cap       <= 2'b00;
      input_voltage_floor_sel <= 3'b000;
      float_voltage_code      <= 6'h00;
      charge_current_code     <= 4'h0;
      charge_enable           <= 1'b0;
      input_switch_on         <= 1'b0;
      sleep_mode              <= 1'b0;
    end
    else
    begin
      input_current_cap       <= limit_reg[7:6];
      input_voltage_floor_sel <= floor_reg;
      float_voltage_code      <= float_reg;
      // foldback overrides the code but not the register, so the
      // programmed current returns as soon as the die cools
      charge_current_code     <= flags_reg.foldback ? FOLDBACK_CODE :
                                 current_reg;
      // sleep also stops charging while it blocks reverse current
      charge_enable   <= state_reg == ST_CHARGE && !sleep_mode;
      input_switch_on <= state_reg != ST_OVP;
      sleep_mode      <= flags_reg.sleep && !flags_reg.undervolt;
    end
  end

endmodule

// ---- tb/charger_limit_protect_logic_chk.sv ----
`timescale 1ns/100ps
module charger_limit_protect_logic_chk #(
  parameter int PULSE_COUNT = 1280  // status pulse length in cycles
) (
  // clock and reset
  input wire logic                       pclk,
  input wire logic                       presetn,
  // apb answer
  input wire logic                       psel,
  input wire logic                       penable,
  input wire logic                       pready,
  input wire logic                       pslverr,
  // comparators and analog controls
  input wire charger_pkg::analog_flags_t flags_async,
  input wire logic [5:0]                 float_voltage_code,
  input wire logic [3:0]                 charge_current_code,
  input wire logic                       charge_enable,
  input wire logic                       input_switch_on,
  input wire logic                       sleep_mode,
  input wire logic                       status_pulse
);
  import charger_pkg::*;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // four flag samples span the synchroniser and output stage; outputs
  // that follow the state machine get one extra cycle
  logic [15:0] pulse_len;  // cycles the status pulse has stood
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pulse_len <= 16'h0000;
    else
      pulse_len <= status_pulse ? pulse_len + 16'h0001 : 16'h0000;
  end
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no answer");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("stray error");
  property p_pulse;
    $fell(status_pulse) |-> pulse_len == 16'(PULSE_COUNT);
  endproperty
  a_pulse: assert property (p_pulse) else $error("pulse width");
  property p_caps;
    float_voltage_code <= 6'h2F && charge_current_code <= ICEIL_TOP;
  endproperty
  a_caps: assert property (p_caps) else $error("code above cap");
  property p_fold;
    flags_async.foldback [*4] |=> charge_current_code == FOLDBACK_CODE;
  endproperty
  a_fold: assert property (p_fold) else $error("no foldback");
  property p_tsd; flags_async.shutdown [*4] |-> ##2 !charge_enable;
  endproperty
  a_tsd: assert property (p_tsd) else $error("hot charge");
  property p_uv; flags_async.undervolt [*4] |-> ##2 !charge_enable;
  endproperty
  a_uv: assert property (p_uv) else $error("low input charge");
  property p_ovp;
    flags_async.overvolt [*4] |-> ##2 !input_switch_on && !charge_enable;
  endproperty
  a_ovp: assert property (p_ovp) else $error("switch on");
  property p_sleep;
    (flags_async.sleep && !flags_async.undervolt) [*4] |=> sleep_mode;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep");
  c_pulse: cover property ($rose(status_pulse));
  c_err: cover property (pslverr);
  c_sleep: cover property ($rose(sleep_mode));
endmodule
bind charger_limit_protect_logic charger_limit_protect_logic_chk #(
  .PULSE_COUNT(PULSE_COUNT)
) i_charger_limit_protect_logic_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .flags_async(flags_async),
  .float_voltage_code(float_voltage_code),
  .charge_current_code(charge_current_code),
  .charge_enable(charge_enable), .input_switch_on(input_switch_on),
  .sleep_mode(sleep_mode), .status_pulse(status_pulse));

// ---- tb/analog_side_model.sv ----
`timescale 1ns/100ps
module analog_side_model (
  // supply band: 0 normal 1 sleep 2 under 3 over 4 hysteresis
  input  wire logic [2:0]            vin,
  // die band: 0 cool 1 foldback 2 shutdown
  input  wire logic [1:0]            temp,
  // battery short, input loop limiting
  input  wire logic                  batt_short,
  input  wire logic                  input_voltage_limiting_flag,
  // comparator levels, unrelated in phase to the clock
  output charger_pkg::analog_flags_t flags_async
);
  import charger_pkg::*;
  // one consistent flag set per band; an input below its undervoltage
  // level is below the sleep level too, and skew keeps edges off pclk
  assign #37 flags_async = '{
    foldback:   temp != 2'd0,
    shutdown:   temp == 2'd2,
    undervolt:  vin == 3'd2,
    overvolt:   vin == 3'd3,
    ovp_clear:  vin < 3'd3,
    sleep:      vin == 3'd1 || vin == 3'd2,
    short_batt: batt_short,
    vin_limit:  input_voltage_limiting_flag};
endmodule

// ---- tb/charger_limit_protect_logic_test.sv ----
`timescale 1ns/100ps
module charger_limit_protect_logic_test;
  import charger_pkg::*;
  // noted answer: write, expected byte, error, compare mask
  typedef struct {logic w; logic [7:0] e; logic er; logic [7:0] m;} note_t;
  logic          pclk, presetn, psel, penable, pwrite, batt_short, input_voltage_limiting_flag;
  logic          pready, pslverr, charge_enable, input_switch_on;
  logic          sleep_mode, status_pulse;
  logic [1:0]    input_current_cap, temp;
  logic [2:0]    input_voltage_floor_sel, vin;
  logic [3:0]    charge_current_code, c;
  logic [5:0]    float_voltage_code;
  logic [7:0]    msk;       // mask put on the notes of later reads
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata;
  analog_flags_t flags_async;
  note_t         nt, q[$];  // expected answers, oldest first
  int            error_cnt, compares, r;
  logic [7:0]    ids[7] = '{IDX_FAULT, IDX_LIMIT, IDX_FLOAT, IDX_CURRENT,
                            IDX_FLOOR, IDX_CEILING, IDX_STATUS};
  // watched levels: pulse, charge enable, input switch, sleep
  wire  [3:0]    mon = {status_pulse, charge_enable, input_switch_on,
                        sleep_mode};
  charger_limit_protect_logic #(.RETRY_COUNT(40), .PULSE_COUNT(4))
  i_charger_limit_protect_logic (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flags_async(flags_async),
    .input_current_cap(input_current_cap),
    .input_voltage_floor_sel(input_voltage_floor_sel),
    .float_voltage_code(float_voltage_code),
    .charge_current_code(charge_current_code),
    .charge_enable(charge_enable), .input_switch_on(input_switch_on),
    .sleep_mode(sleep_mode), .status_pulse(status_pulse));
  analog_side_model i_analog_side_model (
    .vin(vin), .temp(temp), .batt_short(batt_short), .input_voltage_limiting_flag(input_voltage_limiting_flag),
    .flags_async(flags_async));
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic end_of_test();
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer; held until pready is seen at a rising edge
  task automatic apb(logic w, logic [7:0] i, d, e, logic er);
    int n;
    @(posedge pclk);
    {psel, penable, pwrite} <= {2'b10, w};
    paddr <= {2'b00, i, 2'b00};
    pwdata <= {24'h00_0000, d};
    q.push_back('{w, e, er, msk});
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; pready !== 1'b1; n++)
    begin
      if (n == 20)
      begin
        chk("pready", 8'h01, pready);
        end_of_test();
      end
      @(posedge pclk);
    end
    {psel, penable} <= 2'b00;
    @(negedge pclk);
  endtask
  task automatic wr(logic [7:0] i, d);
    apb(1'b1, i, d, 8'h00, 1'b0);
  endtask
  task automatic rd(logic [7:0] i, e);
    apb(1'b0, i, 8'h00, e, 1'b0);
  endtask
  // bounded wait for one watched level
  task automatic wt(int b, logic v);
    int n;
    for (n = 0; mon[b] !== v && n < 60; n++)
      @(negedge pclk);
    chk("level", v, mon[b]);
    if (mon[b] !== v)
      end_of_test();
  endtask
  // answers are compared at the edge that completes the transfer
  always @(posedge pclk)
  begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1)
    begin
      nt = q.pop_front();
      chk("pslverr", nt.er, pslverr);
      if (!nt.w && !nt.er)
        chk("prdata", nt.e, prdata[7:0] & nt.m);
    end
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, vin, temp, input_voltage_limiting_flag} = '0;
    {presetn, batt_short, msk, error_cnt, compares} = {2'b01, 8'hFF, 64'h0};
    r = $urandom(32'hd470);
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ids[k]) rd(ids[k], 8'h00);
    apb(1'b0, 8'h03, 8'h00, 8'h00, 1'b1);
    // short battery: ceiling writes fall away
    wr(IDX_CEILING, 8'h5B);
    wr(IDX_CEILING, 8'h5B);
    rd(IDX_CEILING, CEILING_RST);
    batt_short <= 1'b0;
    repeat (6) @(negedge pclk);
    // a stray first write gives way to the matching pair
    wr(IDX_CEILING, 8'h3C);
    wr(IDX_CEILING, 8'hFF);
    wr(IDX_CEILING, 8'hFF);
    rd(IDX_CEILING, 8'hFF);
    wr(IDX_FLOAT, 8'hFC);
    rd(IDX_FLOAT, 8'hBC);
    chk("float", 8'h2F, float_voltage_code);
    wr(IDX_CURRENT, 8'hF0);
    rd(IDX_CURRENT, 8'hA0);
    repeat (3)
    begin
      c = 4'($urandom % 10);
      wr(IDX_CURRENT, {c, 4'h0});
      rd(IDX_CURRENT, {c, 4'h0});
      chk("current", c, charge_current_code);
    end
    // once the matching pair is written the ceiling is locked
    wr(IDX_CEILING, 8'h5B);
    wr(IDX_CEILING, 8'h5B);
    rd(IDX_CEILING, 8'hFF);
    wr(IDX_FAULT, 8'h07);
    rd(IDX_FAULT, FAULT_NONE);
    batt_short <= 1'b1;
    repeat (6) @(negedge pclk);
    batt_short <= 1'b0;
    repeat (6) @(negedge pclk);
    rd(IDX_CEILING, CEILING_RST);
    wr(IDX_CEILING, 8'h5B);
    for (int k = 0; k < 8; k++)
    begin
      wr(IDX_LIMIT, 8'(k << 6));
      wr(IDX_FLOOR, 8'(k));
      @(negedge pclk);
      chk("cap", 8'(k % 4), input_current_cap);
      chk("floor", 8'(k), input_voltage_floor_sel);
    end
    // the limit writes shut the window: a matching second write is lost
    wr(IDX_CEILING, 8'h5B);
    rd(IDX_CEILING, CEILING_RST);
    batt_short <= 1'b1;
    repeat (6) @(negedge pclk);
    batt_short <= 1'b0;
    repeat (6) @(negedge pclk);
    // open ceiling again so foldback and resume currents differ
    wr(IDX_CEILING, 8'h90);
    wr(IDX_CEILING, 8'h90);
    rd(IDX_CEILING, 8'h90);
    input_voltage_limiting_flag <= 1'b1;
    repeat (6) @(negedge pclk);
    rd(IDX_FLOOR, 8'h0F);
    input_voltage_limiting_flag <= 1'b0;
    wr(IDX_CURRENT, 8'h90);
    wt(2, 1'b1);
    temp <= 2'd1;
    repeat (6) @(negedge pclk);
    chk("fold", FOLDBACK_CODE, charge_current_code);
    temp <= 2'd2;
    wt(3, 1'b1);
    wt(2, 1'b0);
    rd(IDX_FAULT, FAULT_TSD);
    temp <= 2'd1;
    repeat (6) @(negedge pclk);
    chk("hot", 8'h00, charge_enable);
    temp <= 2'd0;
    wt(2, 1'b1);
    chk("resume", 8'h09, charge_current_code);
    vin <= 3'd1;
    wt(0, 1'b1);
    wt(2, 1'b0);
    vin <= 3'd0;
    wt(2, 1'b1);
    vin <= 3'd2;
    wt(3, 1'b1);
    wt(2, 1'b0);
    chk("sleep", 8'h00, sleep_mode);
    rd(IDX_FAULT, FAULT_UV);
    msk = 8'h03;
    rd(IDX_STATUS, STATUS_FAULT);
    vin <= 3'd0;
    repeat (5) @(negedge pclk);
    chk("early", 8'h00, charge_enable);
    wt(2, 1'b1);
    vin <= 3'd3;
    wt(3, 1'b1);
    wt(1, 1'b0);
    wt(2, 1'b0);
    rd(IDX_STATUS, STATUS_FAULT);
    msk = 8'hFF;
    rd(IDX_FAULT, FAULT_OVP);
    vin <= 3'd4;
    repeat (6) @(negedge pclk);
    chk("band", 8'h00, input_switch_on);
    vin <= 3'd0;
    wt(1, 1'b1);
    wt(2, 1'b1);
    end_of_test();
  end
endmodule
